// ===== hdl/eisa_grant_consts.svh
// constants for the slot-master grant block
// assumes a single 20 MHz clock that stands for the expansion-bus clock
//
// Notes on behaviour
// - four-slot mode: the four acknowledge pins are individual per-slot grant lines
// - more than four slots: acknowledge pins carry an encoded grant number
// - grant is asserted on a rising clock edge; master drives on next fall
// - grant holds until the rising edge where the request is seen negated
// - another pending requester preempts the owner while it still requests
// - with others waiting, a new grant still stands at least one clock
// - all acknowledge outputs are negated during and on leaving reset
// - encoded grants share the timing of individual grants
// - mode-select bits 1 and 0 pick individual or encoded format
`ifndef EISA_GRANT_CONSTS_SVH
`define EISA_GRANT_CONSTS_SVH

// clock
`define CLOCK_PERIOD_NS     50

// timing figures in their own units
`define MIN_HOLD_BCLK       1
`define RELEASE_MAX_US      8

// derived cycle counts, longest time rounded down
`define MIN_HOLD_CYCLES     (`MIN_HOLD_BCLK)
`define RELEASE_MAX_CYCLES  ((`RELEASE_MAX_US * 1000) / `CLOCK_PERIOD_NS)

// request masks per mode-select value
`define SLOT_MASK_MODE0     8'h0F
`define SLOT_MASK_MODE1     8'h1F
`define SLOT_MASK_MODE2     8'h7F
`define SLOT_MASK_MODE3     8'hFF

// reset and idle values
`define ACK_IDLE            4'hF
`define PCI_INTERRUPT_REQUEST_IN_IDLE           4'hF
`define MREQ_IDLE           8'hFF

`endif

// ===== hdl/eisa_grant_pkg.sv
// types shared by the slot-master grant block
// assumes the constants header is compiled alongside
package eisa_grant_pkg;

    // grant state, gray coded along idle -> granted -> releasing
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_GRANTED = 2'b01,
        ST_RELEASE = 2'b11
    } grant_state_t;

    // acknowledge format chosen by mode select
    typedef enum logic [1:0] {
        MODE_FOUR_SLOTS  = 2'b00,
        MODE_FIVE_SLOTS  = 2'b01,
        MODE_SEVEN_SLOTS = 2'b10,
        MODE_EIGHT_SLOTS = 2'b11
    } slot_mode_t;

    // who owns the bus, as seen by neighbouring logic
    typedef struct packed {
        logic       active;
        logic       releasing;
        logic [2:0] slot;
    } grant_status_t;

endpackage

// ===== hdl/eisa_master_grant_interface.sv
// grant side of the slot bus-master handshake
// assumes request pins come from outside the clock domain and are
// synchronised here; mode select and other requests come from same-clock logic
`timescale 1ns/10ps
`include "eisa_grant_consts.svh"
`default_nettype none

module eisa_master_grant_interface (
    // clock and reset
    input  wire logic                          i_clock,
    input  wire logic                          i_rst,
    // configuration
    input  wire eisa_grant_pkg::slot_mode_t    i_mode_select,
    // master request pins, active low
    input  wire logic [7:0]                    i_mreq_n,
    // other bus requesters: refresh, dma, isa masters
    input  wire logic                          i_refresh_req,
    input  wire logic                          i_other_req,
    // acknowledge pins: individual or encoded
    output logic [3:0]                         o_ack_n,
    // shared pins handed to the interrupt logic, active low
    output logic [3:0]                         o_pci_interrupt_request_in_n,
    // status
    output eisa_grant_pkg::grant_status_t      o_grant_status,
    output logic                               o_release_overrun
);
    import eisa_grant_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [7:0]    mreq_meta_reg;
    logic [7:0]    mreq_sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mreq_meta_reg <= `MREQ_IDLE;
            mreq_sync_reg <= `MREQ_IDLE;
        end else begin
            mreq_meta_reg <= i_mreq_n;
            mreq_sync_reg <= mreq_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin sharing by mode

    logic [7:0]    slot_mask;
    logic [7:0]    req_vec;
    logic          encoded_mode;

    // mode select is same-clock logic, so it feeds the mask without a synchroniser
    // upper pins become requests as the slot count grows
    always_comb begin
        case (i_mode_select)
            MODE_FOUR_SLOTS:  slot_mask = `SLOT_MASK_MODE0;
            MODE_FIVE_SLOTS:  slot_mask = `SLOT_MASK_MODE1;
            MODE_SEVEN_SLOTS: slot_mask = `SLOT_MASK_MODE2;
            MODE_EIGHT_SLOTS: slot_mask = `SLOT_MASK_MODE3;
            default:          slot_mask = `SLOT_MASK_MODE0;
        endcase
    end

    assign req_vec      = ~mreq_sync_reg & slot_mask;
    assign encoded_mode = (i_mode_select != MODE_FOUR_SLOTS);

    logic [3:0]    pci_interrupt_request_in_next;
    logic [3:0]    pci_interrupt_request_in_reg;

    // interrupt k sits on pin 7-k; pins taken as requests read negated
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            pci_interrupt_request_in_next[k] = slot_mask[7 - k] | mreq_sync_reg[7 - k];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pci_interrupt_request_in_reg <= `PCI_INTERRUPT_REQUEST_IN_IDLE;
        end else begin
            pci_interrupt_request_in_reg <= pci_interrupt_request_in_next;
        end
    end

    assign o_pci_interrupt_request_in_n = pci_interrupt_request_in_reg;

    ////////////////////////////////////////////////////////////////////////////
    // round-robin pick among slot requests

    // scans from the slot after the last owner so no slot starves
    function automatic logic [2:0] pick_next(input logic [7:0] req,
                                             input logic [2:0] last);
        logic [2:0] idx;
        logic       found;
        pick_next = last;
        found     = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            idx = 3'(int'(last) + i);
            if (req[idx] && !found) begin
                pick_next = idx;
                found     = 1'b1;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // grant state machine

    grant_state_t  state_reg;
    grant_state_t  state_next;
    logic [2:0]    slot_reg;
    logic [2:0]    slot_next;
    logic [7:0]    cnt_reg;
    logic [7:0]    cnt_next;
    logic          overrun_reg;
    logic          overrun_next;
    logic          owner_req;
    logic          others_waiting;
    logic [7:0]    owner_onehot;

    // owner and competitor views of the synchronised requests
    assign owner_onehot   = 8'h01 << slot_reg;
    assign owner_req      = |(req_vec & owner_onehot);
    assign others_waiting = i_refresh_req | i_other_req | |(req_vec & ~owner_onehot);

    // counter measures grant age, then time spent waiting for release
    always_comb begin
        state_next   = state_reg;
        slot_next    = slot_reg;
        // saturating, so a stuck owner cannot wrap the release timer
        cnt_next     = (cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01;
        overrun_next = overrun_reg;
        case (state_reg)
            ST_IDLE: begin
                cnt_next     = 8'h00;
                overrun_next = 1'b0;
                // other requesters own the bus first; grant only when clear
                if ((|req_vec) && !i_refresh_req && !i_other_req) begin
                    state_next = ST_GRANTED;
                    slot_next  = pick_next(req_vec, slot_reg);
                end
            end
            ST_GRANTED: begin
                // the grant was registered an edge ago, so it has stood a clock
                if (!owner_req) begin
                    state_next = ST_IDLE;
                end else if (others_waiting &&
                             (cnt_reg >= 8'(`MIN_HOLD_CYCLES - 1))) begin
                    state_next = ST_RELEASE;
                    cnt_next   = 8'h00;
                end
            end
            ST_RELEASE: begin
                // the master finishes its last cycle before letting go
                if (!owner_req) begin
                    state_next = ST_IDLE;
                end else if (cnt_reg >= 8'(`RELEASE_MAX_CYCLES - 1)) begin
                    overrun_next = 1'b1;
                    // only reported: the bus is not handed on until release
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg   <= ST_IDLE;
            slot_reg    <= 3'h7;
            cnt_reg     <= 8'h00;
            overrun_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            slot_reg    <= slot_next;
            cnt_reg     <= cnt_next;
            overrun_reg <= overrun_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // acknowledge outputs, registered from the next state

    logic [3:0]     ack_next;
    logic [3:0]     ack_reg;
    grant_status_t  status_next;
    grant_status_t  status_reg;

    // a mode change while granted reformats the ack; an owner whose slot leaves the new mask loses the grant
    // both formats come from the same state, so timing is shared
    always_comb begin
        ack_next = `ACK_IDLE;
        if (state_next == ST_GRANTED) begin
            if (encoded_mode) begin
                ack_next = {1'b0, slot_next};
            end else begin
                ack_next = ~(4'h1 << slot_next[1:0]);
            end
        end
        status_next.active    = (state_next != ST_IDLE);
        status_next.releasing = (state_next == ST_RELEASE);
        status_next.slot      = slot_next;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ack_reg    <= `ACK_IDLE;
            status_reg <= '0;
        end else begin
            ack_reg    <= ack_next;
            status_reg <= status_next;
        end
    end

    // masters sample on the falling edge, half a cycle after these settle
    assign o_ack_n           = ack_reg;
    assign o_grant_status    = status_reg;
    assign o_release_overrun = overrun_reg;

endmodule

`default_nettype wire

// ===== testbench/eisa_master_grant_interface_props.sv
// checker for the slot-master grant block
// assumes it is bound to the top ports; bind below
`timescale 1ns/10ps
`default_nettype none
module grant_props
    import eisa_grant_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire slot_mode_t i_mode_select,
    input wire logic [7:0] i_mreq_n,
    input wire logic       i_refresh_req,
    input wire logic       i_other_req,
    input wire logic [3:0] o_ack_n,
    input wire logic [3:0] o_pci_interrupt_request_in_n
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // format follows mode one edge late, so mode must sit still first
    wire four = i_mode_select == MODE_FOUR_SLOTS;
    wire idle = o_ack_n == 4'hF;
    wire busy = i_refresh_req || i_other_req;
    sequence mode_held;
        $stable(i_mode_select) ##1 $stable(i_mode_select);
    endsequence
    sequence owner_up;
        four && !idle && (i_mreq_n[3:0] | o_ack_n) == 4'hF;
    endsequence
    //////////////////////////////////////////////////////////////////////
    ack_reset_a: assert property ($fell(i_rst) |-> idle)
        else $error("grant seen right after reset");
    four_format_a: assert property (mode_held ##0 four |-> idle || $onehot(~o_ack_n))
        else $error("individual grant not one line");
    enc_format_a: assert property (mode_held ##0 !four |-> idle || !o_ack_n[3])
        else $error("encoded grant malformed");
    refused_a: assert property (idle && busy |=> idle)
        else $error("grant given while bus wanted");
    preempt_a: assert property (!idle && busy |-> ##[1:2] idle)
        else $error("owner not preempted");
    hold_a: assert property (mode_held ##0 !idle && !$past(idle) |-> $stable(o_ack_n))
        else $error("grant moved without idle gap");
    release_a: assert property (mode_held ##0 owner_up |-> ##[1:4] idle)
        else $error("grant kept after request gone");
    pins_a: assert property (mode_held ##0 i_mode_select == MODE_EIGHT_SLOTS
        |-> o_pci_interrupt_request_in_n == 4'hF)
        else $error("shared pin not a request");
endmodule
bind eisa_master_grant_interface grant_props u_props (.i_clock, .i_rst, .i_mode_select,
    .i_mreq_n, .i_refresh_req, .i_other_req, .o_ack_n, .o_pci_interrupt_request_in_n);
`default_nettype wire

// ===== testbench/slot_master_model.sv
// slot masters on the far side of the grant pins
// assumes grant format set by the shared mode select
`timescale 1ns/10ps
`default_nettype none
module slot_master_model
    import eisa_grant_pkg::*;
(
    input  wire logic       i_clock,
    input  wire slot_mode_t i_mode_select,
    input  wire logic [7:0] i_want,
    input  wire logic [3:0] i_ack_n,
    input  wire logic [7:0] i_hold,
    output logic [7:0]      o_mreq_n
);
    logic [7:0] owns = 8'h00;
    logic [7:0] lost = 8'h00;
    logic [7:0] pin_reg = 8'hFF;
    logic       g;
    // a holding master ignores preemption to exercise the overrun flag
    assign o_mreq_n = pin_reg;
    // grant looked at on the falling edge; a preempted master stays off
    always @(negedge i_clock) begin
        for (int i = 0; i < 8; i++) begin
            g = four_g(i) ? 1'b1 : 1'b0;
            if (!i_want[i] || (owns[i] && !g && !i_hold[i]))
                pin_reg[i] <= 1'b1;
            else if (!lost[i])
                pin_reg[i] <= 1'b0;
            lost[i] <= i_want[i] && !i_hold[i] && (lost[i] || (owns[i] && !g));
            owns[i] <= g;
        end
    end
    function automatic logic four_g(input int i);
        if (i_mode_select == MODE_FOUR_SLOTS)
            return i < 4 && !i_ack_n[i % 4];
        return !i_ack_n[3] && i_ack_n[2:0] == 3'(i);
    endfunction
endmodule
`default_nettype wire

// ===== testbench/test_eisa_master_grant_interface.sv
// bench for the slot-master grant block
// assumes the slot master model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module test_eisa_master_grant_interface;
    import eisa_grant_pkg::*;
    logic          i_clock = 1'b0;
    logic          i_rst = 1'b1;
    logic          refresh_req = 1'b0;
    logic          other_req = 1'b0;
    slot_mode_t    mode = MODE_FOUR_SLOTS;
    logic [7:0]    want = 8'h00;
    logic [7:0]    hold = 8'h00;
    logic [15:0]   rnd = 16'h8027;
    logic [7:0]    mreq_n;
    logic [3:0]    ack_n;
    logic [3:0]    pins_n;
    grant_status_t status;
    logic          overrun;
    int            fail_count = 0;
    int            comparisons = 0;
    int            cycles = 0;
    int            slot;
    always #25 i_clock = ~i_clock;
    eisa_master_grant_interface dut (.i_clock, .i_rst, .i_mode_select(mode), .i_mreq_n(mreq_n),
        .i_refresh_req(refresh_req), .i_other_req(other_req), .o_ack_n(ack_n),
        .o_pci_interrupt_request_in_n(pins_n), .o_grant_status(status), .o_release_overrun(overrun));
    slot_master_model masters (.i_clock, .i_mode_select(mode), .i_want(want), .i_ack_n(ack_n),
        .i_hold(hold), .o_mreq_n(mreq_n));
    //////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [3:0] exp_ack(input slot_mode_t m, input int s);
        return (m == MODE_FOUR_SLOTS) ? ~(4'h1 << s) : {1'b0, 3'(s)};
    endfunction
    function automatic int slots(input slot_mode_t m);
        return (m == MODE_FOUR_SLOTS) ? 4 : (m == MODE_FIVE_SLOTS) ? 5 : (m == MODE_SEVEN_SLOTS) ? 7 : 8;
    endfunction
    task automatic compare(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // overrun flag and grant status checked as one word
    task automatic compare_state(input logic [5:0] got, input logic [5:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t state %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait, sampled 1 ns after the edge so outputs have settled
    task automatic wait_ack(input logic granted);
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            #1;
            n++;
        end while ((ack_n != 4'hF) !== granted && n < 20);
    endtask
    task automatic request(input int s);
        @(posedge i_clock);
        want[s] <= 1'b1;
        wait_ack(1'b1);
        compare(ack_n, exp_ack(mode, s));
        compare_state({overrun, status}, {3'b010, 3'(s)});
    endtask
    task automatic release_all;
        @(posedge i_clock);
        want <= 8'h00;
        wait_ack(1'b0);
        compare(ack_n, 4'hF);
    endtask
    task automatic finish_test;
        $display("fail_count %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the run needs
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            finish_test;
        end
    end
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        wait_ack(1'b0);
        compare(ack_n, 4'hF);
        for (int m = 0; m < 4; m++) begin
            @(posedge i_clock);
            mode <= slot_mode_t'(m);
            for (int k = 0; k < 3; k++) begin
                rnd = lfsr(rnd);
                slot = (k == 0) ? slots(slot_mode_t'(m)) - 1 : rnd % slots(slot_mode_t'(m));
                request(slot);
                release_all;
            end
        end
        compare(pins_n, 4'hF);
        @(posedge i_clock);
        mode <= MODE_FOUR_SLOTS;
        want[7] <= 1'b1;
        repeat (6) @(posedge i_clock);
        #1;
        compare(pins_n, 4'hE);
        release_all;
        request(1);
        @(posedge i_clock);
        refresh_req <= 1'b1;
        want[2] <= 1'b1;
        wait_ack(1'b0);
        compare(ack_n, 4'hF);
        @(posedge i_clock);
        refresh_req <= 1'b0;
        other_req <= 1'b1;
        repeat (8) @(posedge i_clock);
        #1;
        compare(ack_n, 4'hF);
        @(posedge i_clock);
        other_req <= 1'b0;
        wait_ack(1'b1);
        compare(ack_n, exp_ack(MODE_FOUR_SLOTS, 2));
        release_all;
        // a master that keeps requesting after preemption trips the overrun flag
        @(posedge i_clock);
        hold[0] <= 1'b1;
        request(0);
        @(posedge i_clock);
        other_req <= 1'b1;
        @(posedge i_clock);
        other_req <= 1'b0;
        repeat (170) @(posedge i_clock);
        #1;
        compare(ack_n, 4'hF);
        compare_state({overrun, status}, 6'h38);
        @(posedge i_clock);
        hold <= 8'h00;
        want <= 8'h00;
        repeat (5) @(posedge i_clock);
        #1;
        compare_state({overrun, status}, 6'h00);
        finish_test;
    end
endmodule
`default_nettype wire
